//--- rtl/gpde_pin_if.sv
// Interface carrying one 8-bit port's pin-side signals between modules.
`timescale 1ns/1ps
`default_nettype none
interface gpde_pin_if;
    logic [7:0] latch;     // Software data latch.
    logic [7:0] dir;       // Software direction bits.
    logic [7:0] alt_claim; // Alternate function owns the pin.
    logic [7:0] alt_oe;    // Alternate output enable.
    logic [7:0] alt_out;   // Alternate drive value.
    logic [7:0] zero_rd;   // Force read of zero where the pin is an input.
    logic [7:0] pin_sync;  // Synchronised pin level.
    logic [7:0] oe;        // Resolved output enable.
    logic [7:0] out;       // Resolved output value.
    logic [7:0] rd;        // Value a port read returns.
    modport ctrl (output latch, dir, alt_claim, alt_oe, alt_out, zero_rd,
                  input pin_sync, oe, out, rd);
    modport pin  (input latch, dir, alt_claim, alt_oe, alt_out, zero_rd,
                  output oe, out, rd, input pin_sync);
endinterface : gpde_pin_if
`default_nettype wire

//--- rtl/gpde_pkg.sv
// Package of constants and types for the port D / port E pin block.
package gpde_pkg;
    // Bus and data widths.
    localparam int unsigned ADDR_W = 6;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned PORT_W = 8;
    // Printed offsets; not all are multiples of four, so they are word indices.
    localparam logic [3:0] IDX_PORT_D_LATCH = 4'h3;
    localparam logic [3:0] IDX_PORT_D_DIR   = 4'h7;
    localparam logic [3:0] IDX_PORT_E_LATCH = 4'h8;
    localparam logic [3:0] IDX_PORT_E_DIR   = 4'hc;
    localparam logic [3:0] IDX_ALT_CTRL     = 4'hd;
    localparam logic [3:0] IDX_PIN_STATE    = 4'he;
    // Byte address is four times the index.
    localparam logic [ADDR_W-1:0] ADR_PORT_D_LATCH = 6'h0c;
    localparam logic [ADDR_W-1:0] ADR_PORT_D_DIR   = 6'h1c;
    localparam logic [ADDR_W-1:0] ADR_PORT_E_LATCH = 6'h20;
    localparam logic [ADDR_W-1:0] ADR_PORT_E_DIR   = 6'h30;
    localparam logic [ADDR_W-1:0] ADR_ALT_CTRL     = 6'h34;
    localparam logic [ADDR_W-1:0] ADR_PIN_STATE    = 6'h38;
    // Reset values.
    localparam logic [PORT_W-1:0] DIR_RST   = 8'h00;
    localparam logic [15:0]       ALT_RST   = 16'h0000;
    localparam logic [DATA_W-1:0] RD_UNMAP  = 32'h0000_0000;
    // Alternate control register field positions.
    localparam int unsigned F_CONV_SEL  = 0;   // [4:0] converter channel select.
    localparam int unsigned F_CONV_EN   = 5;   // Converter claims selected channel.
    localparam int unsigned F_TA_EXT    = 6;   // Timer A prescaler on external clock.
    localparam int unsigned F_TB_EXT    = 7;   // Timer B prescaler on external clock.
    localparam int unsigned F_SPI_EN    = 8;
    localparam int unsigned F_SPI_MSTR  = 9;
    localparam int unsigned F_MODF_EN   = 10;
    localparam int unsigned F_TCH0_EN   = 11;  // Edge/level select nonzero, channel 0.
    localparam int unsigned F_TCH1_EN   = 12;
    localparam int unsigned F_SCI_EN    = 13;
    localparam int unsigned ALT_W       = 14;
    // Pin positions.
    localparam int unsigned PD_TA_CLK = 6;
    localparam int unsigned PD_TB_CLK = 4;
    localparam int unsigned PD_CONV_N = 7;     // Pins 6..0 carry converter inputs.
    localparam logic [4:0]  CONV_BASE = 5'h08; // Converter input 8 sits on pin 0.
    localparam int unsigned PE_SCK  = 7;
    localparam int unsigned PE_MOSI = 6;
    localparam int unsigned PE_MISO = 5;
    localparam int unsigned PE_SS   = 4;
    localparam int unsigned PE_TCH1 = 3;
    localparam int unsigned PE_TCH0 = 2;
    localparam int unsigned PE_RXD  = 1;
    localparam int unsigned PE_TXD  = 0;
    // Bus slave states.
    typedef enum logic [0:0] {GPDE_IDLE, GPDE_ACK} gpde_bus_state_t;
endpackage : gpde_pkg

//--- rtl/gpde_port_mux.sv
// Pin mux and read-back path for one 8-bit port.
`timescale 1ns/1ps
`default_nettype none
module gpde_port_mux (
    gpde_pin_if.pin p  // Port signals.
);
    // Output ownership: an alternate function overrides latch and direction.
    // alternate owns pin
    assign p.oe  = (p.alt_claim & p.alt_oe) | (~p.alt_claim & p.dir);
    assign p.out = (p.alt_claim & p.alt_out) | (~p.alt_claim & p.latch);

    // Read path: latch where direction is out, else pin or forced zero.
    // output reads latch
    assign p.rd = (p.dir & p.latch) | (~p.dir & ~p.zero_rd & p.pin_sync);
endmodule // gpde_port_mux
`default_nettype wire

//--- rtl/gpde_top.sv
// Port D and port E general-purpose pins with alternate-function sharing.
//
// Local design decision: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Port D latch read/write, direction per bit
// - Direction one enables output buffer
// - Reset clears direction, latches keep contents
// - Output-direction bits read the latch
// - Input-direction bits read the pin (timer-claimed port D pins read zero)
// - Latch writes always land, inputs unaffected
// - Converter channel: input reads zero
// - Timer claims ignore port D direction
// - Pins 6/4 are timer external clocks
// - Selected timer clock ignores direction bit
// - Port E latch read/write, direction per bit
// - Bit 7 serial clock, direction by role
// - Bit 6 master-out line when enabled
// - Bit 5 master-in line when enabled
// - Bit 4 select input, conditional release
// - Slave select ignores direction bit
// - Serial claims ignore port E direction
// - Bits 3/2 timer channels when selected
// - Bit 1 serial receive when enabled
// - Bit 0 serial transmit when enabled
// - Port E direction resets to inputs
// - Port E read: latch or pin
module gpde_top (
    input  wire logic        clk_i,              // System clock, 25 MHz.
    input  wire logic        rst_n_i,            // Asynchronous reset, active low.
    input  wire logic [5:0]  avs_address_i,      // Byte address.
    input  wire logic        avs_read_i,         // Read request.
    input  wire logic        avs_write_i,        // Write request.
    input  wire logic [31:0] avs_writedata_i,    // Write data.
    input  wire logic [3:0]  avs_byteenable_i,   // Byte enables.
    output logic      [31:0] avs_readdata_o,     // Read data, registered.
    output logic             avs_waitrequest_o,  // Stall, high until answer.
    input  wire logic [7:0]  port_d_pin_i,       // Port D pin levels.
    output logic      [7:0]  port_d_pin_o,       // Port D drive values.
    output logic      [7:0]  port_d_pin_oe_o,    // Port D output enables.
    input  wire logic [7:0]  port_e_pin_i,       // Port E pin levels.
    output logic      [7:0]  port_e_pin_o,       // Port E drive values.
    output logic      [7:0]  port_e_pin_oe_o,    // Port E output enables.
    input  wire logic        spi_sck_out_i,      // Serial peripheral clock in master role.
    input  wire logic        spi_mosi_out_i,     // Master-out data from the peripheral.
    input  wire logic        spi_miso_out_i,     // Slave-out data from the peripheral.
    input  wire logic        sci_txd_i,          // Asynchronous serial transmit data.
    input  wire logic [1:0]  tim_ch_out_i,       // Timer channel compare outputs.
    input  wire logic [1:0]  tim_ch_oe_i,        // Timer channel drives its pin.
    output logic      [7:0]  port_d_level_o,     // Synchronised port D levels to peripherals.
    output logic      [7:0]  port_e_level_o,     // Synchronised port E levels to peripherals.
    output logic             timer_a_ext_clock_o, // External clock for timer A.
    output logic             timer_b_ext_clock_o  // External clock for timer B.
);
    // Register state.
    logic [7:0]  port_d_latch_r;             // Port D data latch, not reset.
    logic [7:0]  port_d_dir_r;               // Port D direction.
    logic [7:0]  port_e_latch_r;             // Port E data latch, not reset.
    logic [7:0]  port_e_dir_r;               // Port E direction.
    logic [gpde_pkg::ALT_W-1:0] alt_ctrl_r;  // Alternate-function claims.
    logic [31:0] rdata_nxt;                  // Decoded read value.
    logic        wr_hit;                     // Write accepted this edge.
    logic [3:0]  idx;                        // Word index of the access.

    // Bus handshake state.
    gpde_pkg::gpde_bus_state_t state_r;      // Current bus phase.
    gpde_pkg::gpde_bus_state_t state_nxt;    // Next bus phase.
    logic [31:0] readdata_r;                 // Read data held for the master.
    logic        req;                        // Read or write pending.

    // Pin synchronisers: three stages per port plus the agreed level.
    logic [7:0]  d_s1_r;                     // Port D first stage.
    logic [7:0]  d_s2_r;                     // Port D second stage.
    logic [7:0]  d_s3_r;                     // Port D third stage.
    logic [7:0]  d_lvl_r;                    // Port D agreed level.
    logic [7:0]  e_s1_r;                     // Port E first stage.
    logic [7:0]  e_s2_r;                     // Port E second stage.
    logic [7:0]  e_s3_r;                     // Port E third stage.
    logic [7:0]  e_lvl_r;                    // Port E agreed level.

    // Decoded alternate-function controls.
    logic [4:0]  conv_sel;                   // Converter channel select.
    logic        conv_en;                    // Converter claims its channel.
    logic        ta_ext;                     // Timer A counts the external clock.
    logic        tb_ext;                     // Timer B counts the external clock.
    logic        spi_en;                     // Serial peripheral enabled.
    logic        spi_mstr;                   // Serial peripheral in master role.
    logic        modf_en;                    // Mode-fault detection enabled.
    logic        tch0_en;                    // Timer channel 0 owns its pin.
    logic        tch1_en;                    // Timer channel 1 owns its pin.
    logic        sci_en;                     // Asynchronous serial enabled.
    logic        ss_claim;                   // Select pin held by the peripheral.

    // Per-pin claims and alternate drive.
    logic [7:0]  d_claim;                    // Port D pins taken by converter or timers.
    logic [7:0]  e_claim;                    // Port E pins taken by peripherals.
    logic [7:0]  e_alt_oe;                   // Port E alternate output enables.
    logic [7:0]  e_alt_out;                  // Port E alternate drive values.
    logic        ta_clk_r;                   // Registered timer A external clock.
    logic        tb_clk_r;                   // Registered timer B external clock.

    // Pin-side bundles, one per port.
    gpde_pin_if pd_if ();                    // Port D bundle.
    gpde_pin_if pe_if ();                    // Port E bundle.

    // Merge the low byte lane of a write into an 8-bit register.
    function automatic logic [7:0] lane_merge(
        input logic [7:0]  cur,
        input logic [31:0] wdata,
        input logic        be
    );
        return be ? wdata[7:0] : cur;
    endfunction

    // One-hot mask of the port D pin that carries the selected converter input.
    // Selects outside this port claim nothing, so those pins stay free.
    function automatic logic [7:0] conv_mask(
        input logic [4:0] sel,
        input logic       en
    );
        logic [7:0] m;
        m = 8'h00;
        for (int i = 0; i < gpde_pkg::PD_CONV_N; i++) begin
            if (en && (sel == gpde_pkg::CONV_BASE + 5'(i))) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction

    // Next agreed level: a bit moves only where stages two and three agree.
    function automatic logic [7:0] sync_agree(
        input logic [7:0] s2,
        input logic [7:0] s3,
        input logic [7:0] lvl
    );
        return (s2 & s3) | (lvl & (s2 ^ s3));
    endfunction

    // Word index of the access; the byte offsets are four apart.
    assign idx = avs_address_i[gpde_pkg::ADDR_W-1:2];
    assign req = avs_read_i | avs_write_i;

    // A write lands only on the edge at which waitrequest is low.
    assign wr_hit = (state_r == gpde_pkg::GPDE_ACK) && avs_write_i;

    // Next bus phase: every request waits exactly one cycle.
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            gpde_pkg::GPDE_IDLE: begin
                // A new request is taken in.
                if (req) begin
                    state_nxt = gpde_pkg::GPDE_ACK;
                end
            end
            gpde_pkg::GPDE_ACK: begin
                // The answer stands for one cycle only.
                state_nxt = gpde_pkg::GPDE_IDLE;
            end
        endcase
    end

    // Bus phase register.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r <= gpde_pkg::GPDE_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Read data is captured as a read arrives and stands through the answer.
    // Capturing early costs nothing, since no write can slip in between.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            readdata_r <= gpde_pkg::RD_UNMAP;
        end else if ((state_r == gpde_pkg::GPDE_IDLE) && avs_read_i) begin
            readdata_r <= rdata_nxt;
        end
    end

    assign avs_readdata_o    = readdata_r;
    // Waitrequest is low only in the answer phase.
    assign avs_waitrequest_o = (state_r != gpde_pkg::GPDE_ACK);

    // Read decode; unmapped words return zero.
    always_comb begin
        rdata_nxt = gpde_pkg::RD_UNMAP;
        case (idx)
            gpde_pkg::IDX_PORT_D_LATCH: begin
                rdata_nxt[gpde_pkg::PORT_W-1:0] = pd_if.rd;
            end
            gpde_pkg::IDX_PORT_D_DIR: begin
                rdata_nxt[gpde_pkg::PORT_W-1:0] = port_d_dir_r;
            end
            gpde_pkg::IDX_PORT_E_LATCH: begin
                rdata_nxt[gpde_pkg::PORT_W-1:0] = pe_if.rd;
            end
            gpde_pkg::IDX_PORT_E_DIR: begin
                rdata_nxt[gpde_pkg::PORT_W-1:0] = port_e_dir_r;
            end
            gpde_pkg::IDX_ALT_CTRL: begin
                rdata_nxt[gpde_pkg::ALT_W-1:0] = alt_ctrl_r;
            end
            gpde_pkg::IDX_PIN_STATE: begin
                rdata_nxt[2*gpde_pkg::PORT_W-1:0] = {e_lvl_r, d_lvl_r};
            end
            default: begin
                // Unmapped word.
                rdata_nxt = gpde_pkg::RD_UNMAP;
            end
        endcase
    end

    // latch survives reset
    // The latch has no reset, so its contents ride through one.
    always_ff @(posedge clk_i) begin
        if (wr_hit && (idx == gpde_pkg::IDX_PORT_D_LATCH)) begin
            port_d_latch_r <= lane_merge(port_d_latch_r, avs_writedata_i, avs_byteenable_i[0]);
        end
    end

    // port E latch
    // Same as port D: written whatever the direction, never reset.
    always_ff @(posedge clk_i) begin
        if (wr_hit && (idx == gpde_pkg::IDX_PORT_E_LATCH)) begin
            port_e_latch_r <= lane_merge(port_e_latch_r, avs_writedata_i, avs_byteenable_i[0]);
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            port_d_dir_r <= gpde_pkg::DIR_RST;
        end else if (wr_hit && (idx == gpde_pkg::IDX_PORT_D_DIR)) begin
            port_d_dir_r <= lane_merge(port_d_dir_r, avs_writedata_i, avs_byteenable_i[0]);
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            port_e_dir_r <= gpde_pkg::DIR_RST;
        end else if (wr_hit && (idx == gpde_pkg::IDX_PORT_E_DIR)) begin
            port_e_dir_r <= lane_merge(port_e_dir_r, avs_writedata_i, avs_byteenable_i[0]);
        end
    end

    // Alternate-function claims; reset frees every pin for general use.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            alt_ctrl_r <= gpde_pkg::ALT_RST[gpde_pkg::ALT_W-1:0];
        end else if (wr_hit && (idx == gpde_pkg::IDX_ALT_CTRL)) begin
            alt_ctrl_r <= avs_writedata_i[gpde_pkg::ALT_W-1:0];
        end
    end

    // Field decode of the claim register.
    assign conv_sel = alt_ctrl_r[gpde_pkg::F_CONV_SEL +: 5];
    assign conv_en  = alt_ctrl_r[gpde_pkg::F_CONV_EN];
    assign ta_ext   = alt_ctrl_r[gpde_pkg::F_TA_EXT];
    assign tb_ext   = alt_ctrl_r[gpde_pkg::F_TB_EXT];
    assign spi_en   = alt_ctrl_r[gpde_pkg::F_SPI_EN];
    assign spi_mstr = alt_ctrl_r[gpde_pkg::F_SPI_MSTR];
    assign modf_en  = alt_ctrl_r[gpde_pkg::F_MODF_EN];
    assign tch0_en  = alt_ctrl_r[gpde_pkg::F_TCH0_EN];
    assign tch1_en  = alt_ctrl_r[gpde_pkg::F_TCH1_EN];
    assign sci_en   = alt_ctrl_r[gpde_pkg::F_SCI_EN];

    always_comb begin
        d_claim = conv_mask(conv_sel, conv_en);
        d_claim[gpde_pkg::PD_TA_CLK] = d_claim[gpde_pkg::PD_TA_CLK] | ta_ext;
        d_claim[gpde_pkg::PD_TB_CLK] = d_claim[gpde_pkg::PD_TB_CLK] | tb_ext;
    end

    // Port D bundle.
    assign pd_if.latch     = port_d_latch_r;
    assign pd_if.dir       = port_d_dir_r;
    // clock pin stays input
    // Claimed port D pins are inputs whatever the direction bit says.
    assign pd_if.alt_claim = d_claim;
    assign pd_if.alt_oe    = 8'h00;
    assign pd_if.alt_out   = 8'h00;
    // Claimed input bits read zero; output bits still read the latch.
    assign pd_if.zero_rd   = d_claim;
    assign pd_if.pin_sync  = d_lvl_r;

    // select pin release
    // A master without mode-fault detection has no use for its select pin.
    assign ss_claim = spi_en && !(spi_mstr && !modf_en);

    always_comb begin
        e_claim   = 8'h00;
        e_alt_oe  = 8'h00;
        e_alt_out = 8'h00;
        e_claim[gpde_pkg::PE_SCK]    = spi_en;
        e_alt_oe[gpde_pkg::PE_SCK]   = spi_mstr;
        e_alt_out[gpde_pkg::PE_SCK]  = spi_sck_out_i;
        e_claim[gpde_pkg::PE_MOSI]   = spi_en;
        e_alt_oe[gpde_pkg::PE_MOSI]  = spi_mstr;
        e_alt_out[gpde_pkg::PE_MOSI] = spi_mosi_out_i;
        e_claim[gpde_pkg::PE_MISO]   = spi_en;
        e_alt_oe[gpde_pkg::PE_MISO]  = !spi_mstr;
        e_alt_out[gpde_pkg::PE_MISO] = spi_miso_out_i;
        e_claim[gpde_pkg::PE_SS]     = ss_claim;
        e_claim[gpde_pkg::PE_TCH1]   = tch1_en;
        e_alt_oe[gpde_pkg::PE_TCH1]  = tim_ch_oe_i[1];
        e_alt_out[gpde_pkg::PE_TCH1] = tim_ch_out_i[1];
        e_claim[gpde_pkg::PE_TCH0]   = tch0_en;
        e_alt_oe[gpde_pkg::PE_TCH0]  = tim_ch_oe_i[0];
        e_alt_out[gpde_pkg::PE_TCH0] = tim_ch_out_i[0];
        e_claim[gpde_pkg::PE_RXD]    = sci_en;
        e_claim[gpde_pkg::PE_TXD]    = sci_en;
        e_alt_oe[gpde_pkg::PE_TXD]   = 1'b1;
        e_alt_out[gpde_pkg::PE_TXD]  = sci_txd_i;
    end

    // Port E bundle.
    assign pe_if.latch     = port_e_latch_r;
    assign pe_if.dir       = port_e_dir_r;
    assign pe_if.alt_claim = e_claim;
    assign pe_if.alt_oe    = e_alt_oe;
    assign pe_if.alt_out   = e_alt_out;
    // port E read path
    // Port E never forces zero: input bits always read the pin.
    assign pe_if.zero_rd   = 8'h00;
    assign pe_if.pin_sync  = e_lvl_r;

    // Port D mux and read path.
    gpde_port_mux u_mux_d (
        .p (pd_if.pin)  // Port D signals.
    );

    // Port E mux and read path.
    gpde_port_mux u_mux_e (
        .p (pe_if.pin)  // Port E signals.
    );

    // Pin-side outputs.
    assign port_d_pin_o    = pd_if.out;
    assign port_d_pin_oe_o = pd_if.oe;
    assign port_e_pin_o    = pe_if.out;
    assign port_e_pin_oe_o = pe_if.oe;
    assign port_d_level_o  = d_lvl_r;
    assign port_e_level_o  = e_lvl_r;

    // pin level sampled
    // Port D synchroniser: a runt that reaches one stage never reaches a read.
    // The price is four cycles from pin to read value.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            d_s1_r  <= 8'h00;
            d_s2_r  <= 8'h00;
            d_s3_r  <= 8'h00;
            d_lvl_r <= 8'h00;
        end else begin
            d_s1_r  <= port_d_pin_i;
            d_s2_r  <= d_s1_r;
            d_s3_r  <= d_s2_r;
            d_lvl_r <= sync_agree(d_s2_r, d_s3_r, d_lvl_r);
        end
    end

    // Port E synchroniser, built the same way.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            e_s1_r  <= 8'h00;
            e_s2_r  <= 8'h00;
            e_s3_r  <= 8'h00;
            e_lvl_r <= 8'h00;
        end else begin
            e_s1_r  <= port_e_pin_i;
            e_s2_r  <= e_s1_r;
            e_s3_r  <= e_s2_r;
            e_lvl_r <= sync_agree(e_s2_r, e_s3_r, e_lvl_r);
        end
    end

    // timer clock outputs
    // The clock reaches a timer only while its prescaler picks the pin.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ta_clk_r <= 1'b0;
            tb_clk_r <= 1'b0;
        end else begin
            ta_clk_r <= ta_ext & d_lvl_r[gpde_pkg::PD_TA_CLK];
            tb_clk_r <= tb_ext & d_lvl_r[gpde_pkg::PD_TB_CLK];
        end
    end

    assign timer_a_ext_clock_o = ta_clk_r;
    assign timer_b_ext_clock_o = tb_clk_r;

    // Checks on the bus and the pin claims, all in the system clock domain.
    default clocking cb_sys @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // A request taken in while idle.
    sequence s_req_seen;
        (state_r == gpde_pkg::GPDE_IDLE) && req;
    endsequence

    // The answer phase.
    sequence s_answer;
        !avs_waitrequest_o;
    endsequence

    // A read of the port D data word taken in.
    sequence s_rd_port_d;
        (state_r == gpde_pkg::GPDE_IDLE) && avs_read_i && (idx == gpde_pkg::IDX_PORT_D_LATCH);
    endsequence

    property p_answer_next;
        s_req_seen |=> s_answer;
    endproperty
    a_answer_next: assert property (p_answer_next)
        else $error("bus request not answered in the next cycle");

    property p_dir_write;
        (wr_hit && (idx == gpde_pkg::IDX_PORT_D_DIR) && avs_byteenable_i[0])
            |=> ({24'h000000, port_d_dir_r} == ($past(avs_writedata_i) & 32'h0000_00ff));
    endproperty
    a_dir_write: assert property (p_dir_write)
        else $error("port D direction write did not land");

    property p_d_oe_free;
        ((port_d_pin_oe_o ^ port_d_dir_r) & ~d_claim) == 8'h00;
    endproperty
    a_d_oe_free: assert property (p_d_oe_free)
        else $error("free port D pin enable differs from direction");

    property p_rd_latch;
        s_rd_port_d |=> (((avs_readdata_o[7:0] ^ port_d_latch_r) & port_d_dir_r) == 8'h00);
    endproperty
    a_rd_latch: assert property (p_rd_latch)
        else $error("output bit of port D read is not the latch");

    property p_rd_conv_zero;
        s_rd_port_d |=> ((avs_readdata_o[7:0] & ~port_d_dir_r & d_claim) == 8'h00);
    endproperty
    a_rd_conv_zero: assert property (p_rd_conv_zero)
        else $error("claimed input bit of port D read is not zero");

    property p_ta_input;
        ta_ext |-> !port_d_pin_oe_o[gpde_pkg::PD_TA_CLK];
    endproperty
    a_ta_input: assert property (p_ta_input)
        else $error("timer A clock pin is driven");

    property p_ss_input;
        (spi_en && !spi_mstr) |-> !port_e_pin_oe_o[gpde_pkg::PE_SS];
    endproperty
    a_ss_input: assert property (p_ss_input)
        else $error("slave select pin is driven in slave role");

    property p_txd_drive;
        sci_en |-> (port_e_pin_oe_o[gpde_pkg::PE_TXD] && (port_e_pin_o[gpde_pkg::PE_TXD] == sci_txd_i));
    endproperty
    a_txd_drive: assert property (p_txd_drive)
        else $error("serial transmit pin does not carry transmit data");
endmodule // gpde_top
`default_nettype wire

//--- verification/gpde_pins_model.sv
// Board model: block drive where enabled, outside source elsewhere.
`timescale 1ns/1ps
`default_nettype none
module gpde_pins_model (
    input  wire logic [7:0] oe_i,  // Block output enables.
    input  wire logic [7:0] out_i, // Block drive values.
    input  wire logic [7:0] ext_i, // Outside source level.
    output logic      [7:0] pin_o  // Resolved wire level.
);
    assign pin_o = (oe_i & out_i) | (~oe_i & ext_i);
endmodule // gpde_pins_model
`default_nettype wire

//--- verification/testbench.sv
// Self-checking bench for the port D / port E pin block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk_i = 1'b0, rst_n_i = 1'b0, rd = 1'b0, wr = 1'b0, wq, tac, tbc; // Bus, timer clocks.
    logic [5:0] ad = 6'h00;                           // Bus address.
    logic [31:0] wd = 32'h0, rq, q;                   // Write data, read data, last read.
    logic [7:0] dpi, dpo, doe, epi, epo, eoe, dx = 8'h00, ex = 8'h00, sd = 8'h00, ld, dd, xd;
    int fail_count = 0, num_checks = 0, seed = 32'h6c545560, p;
    initial forever #20 clk_i = ~clk_i;
    gpde_top DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(ad), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hf), .avs_readdata_o(rq),
        .avs_waitrequest_o(wq), .port_d_pin_i(dpi), .port_d_pin_o(dpo), .port_d_pin_oe_o(doe),
        .port_e_pin_i(epi), .port_e_pin_o(epo), .port_e_pin_oe_o(eoe), .spi_sck_out_i(sd[0]),
        .spi_mosi_out_i(sd[1]), .spi_miso_out_i(sd[2]), .sci_txd_i(sd[3]), .tim_ch_out_i(sd[5:4]),
        .tim_ch_oe_i(sd[7:6]), .port_d_level_o(), .port_e_level_o(),
        .timer_a_ext_clock_o(tac), .timer_b_ext_clock_o(tbc));
    gpde_pins_model PD (.oe_i(doe), .out_i(dpo), .ext_i(dx), .pin_o(dpi));
    gpde_pins_model PE (.oe_i(eoe), .out_i(epo), .ext_i(ex), .pin_o(epi));
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Holds the request until waitrequest is seen low, then releases it.
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        int n;
        n = 0;
        ad <= a;
        wr <= w;
        rd <= !w;
        wd <= d;
        do begin @(posedge clk_i); n++; end while (wq !== 1'b0 && n < 40);
        q = {24'h0, rq[7:0]};
        wr <= 1'b0;
        rd <= 1'b0;
        if (n >= 40) begin fail_count++; results(); end
        @(posedge clk_i);
    endtask
    initial begin
        repeat (10) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        bus(0, gpde_pkg::ADR_PORT_D_DIR, 0); chk(q, 0);
        bus(0, gpde_pkg::ADR_PORT_E_DIR, 0); chk(q, 0);
        chk({doe, eoe}, 0);
        bus(0, 6'h04, 0); chk(q, gpde_pkg::RD_UNMAP);
        for (int i = 0; i < 16; i++) begin
            p = i % 2;
            {ld, dd, xd} = 24'($random(seed));
            sd <= 8'($random(seed));
            if (p == 0) dx <= xd; else ex <= xd;
            bus(1, p ? gpde_pkg::ADR_PORT_E_LATCH : gpde_pkg::ADR_PORT_D_LATCH, ld);
            bus(1, p ? gpde_pkg::ADR_PORT_E_DIR : gpde_pkg::ADR_PORT_D_DIR, dd);
            repeat (4) @(posedge clk_i); // Let released pins pass the synchroniser.
            bus(0, p ? gpde_pkg::ADR_PORT_E_LATCH : gpde_pkg::ADR_PORT_D_LATCH, 0);
            chk(q, (ld & dd) | (xd & ~dd));
            chk(p ? eoe : doe, dd);
            chk((p ? epo : dpo) & dd, ld & dd);
        end
        dx <= 8'hff;
        bus(1, gpde_pkg::ADR_PORT_D_DIR, 0);
        for (int k = 0; k < 7; k++) begin
            bus(1, gpde_pkg::ADR_ALT_CTRL, 32'h28 + k);
            bus(0, gpde_pkg::ADR_PORT_D_LATCH, 0); chk(q, 8'hff & ~(8'h1 << k));
        end
        bus(1, gpde_pkg::ADR_PORT_D_DIR, 32'hff);
        for (int t = 0; t < 2; t++) begin
            bus(1, gpde_pkg::ADR_ALT_CTRL, 32'h40 << t);
            chk(doe, t ? 8'hef : 8'hbf);
            repeat (6) @(posedge clk_i);
            chk(t ? tbc : tac, 1);
        end
        bus(1, gpde_pkg::ADR_PORT_E_DIR, 32'hff);
        bus(1, gpde_pkg::ADR_ALT_CTRL, 32'h300); chk(eoe, 8'hdf);
        chk(epo[7:6], {sd[0], sd[1]});
        bus(1, gpde_pkg::ADR_ALT_CTRL, 32'h100); chk(eoe, 8'h2f);
        chk(epo[5], sd[2]);
        bus(1, gpde_pkg::ADR_ALT_CTRL, 32'h2000); chk(eoe, 8'hfd);
        chk(epo[0], sd[3]);
        bus(1, gpde_pkg::ADR_ALT_CTRL, 32'h800); chk(eoe[2], sd[6]);
        bus(1, gpde_pkg::ADR_PORT_D_LATCH, 32'h5a);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        chk({doe, eoe}, 0);
        chk(dpo, 8'h5a);
        results();
    end
endmodule // testbench
`default_nettype wire
